// ### rtl/cmon_adc_path.sv
// channel sequencing, reference selection and result registers of the cell converter
`timescale 1ns/10ps
`include "cmon_map.svh"
module cmon_adc_path #(
	parameter int CH_CYCLES = `CMON_CH_CYCLES,
	parameter int OVH_CYCLES = `CMON_OVH_CYCLES
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire cmon_pkg::cmon_req_t reg_req,
	output logic [7:0] reg_rdata_r,
	input wire logic conv_pin,
	input wire logic signed [`CMON_RAW_W-1:0] adc_raw,
	output cmon_pkg::cmon_fe_t fe_sel_r,
	output logic busy_r,
	output logic data_ready_r
);
	import cmon_pkg::*;

	// ****************************************
	// parameter checks
	// ****************************************
	generate
		if (CH_CYCLES < 2 || CH_CYCLES >= (1 << `CMON_CNT_W)) begin : g_bad_ch
			$error("channel slot count out of range");
		end
		if (OVH_CYCLES < 1 || OVH_CYCLES >= (1 << `CMON_CNT_W)) begin : g_bad_ovh
			$error("overhead count out of range");
		end
	endgenerate

	// ****************************************
	// map consistency checks
	// ****************************************
	generate
		if (`CMON_NUM_CH > (1 << `CMON_CHAN_W) - 1) begin : g_bad_nch
			$error("channel codes collide with the idle code");
		end
		if (`CMON_RES_W + 2 != `CMON_RAW_W) begin : g_bad_pad
			$error("result plus two zero bits must fill a register pair");
		end
		if (`CMON_LAST_RESULT_LOW != `CMON_AUX_RESULT_HIGH + 2 * `CMON_NUM_CH - 1) begin : g_bad_last
			$error("result pairs do not span all channels");
		end
		if (`CMON_CELL1_RESULT_HIGH != `CMON_AUX_RESULT_HIGH + 2) begin : g_bad_c1h
			$error("cell one pair must follow the auxiliary pair");
		end
		if (`CMON_CELL1_RESULT_LOW != `CMON_CELL1_RESULT_HIGH + 1) begin : g_bad_c1l
			$error("cell one low byte must follow its high byte");
		end
		if (`CMON_CH_TS1 != `CMON_CELLS_MAX + 1) begin : g_bad_ts1
			$error("first temperature code must follow the last cell");
		end
		if (`CMON_CH_TS2 != `CMON_CH_TS1 + 1) begin : g_bad_ts2
			$error("temperature codes must be adjacent");
		end
		if (`CMON_CH_AUX != `CMON_CH_TS2 + 1 || `CMON_CH_AUX != `CMON_NUM_CH - 1) begin : g_bad_aux
			$error("auxiliary code must be the last channel");
		end
		if (`CMON_CELLS_RST > `CMON_CELLS_MAX) begin : g_bad_crst
			$error("cell count reset value out of range");
		end
		if ((1 << (`CMON_CELLS_MSB + 1)) <= `CMON_CELLS_MAX) begin : g_bad_cfld
			$error("cell count field too narrow");
		end
		if (`CMON_TS1_BIT <= `CMON_CELLS_MSB || `CMON_TS1_BIT == `CMON_TS2_BIT) begin : g_bad_tsb
			$error("temperature enable bits overlap");
		end
		if (`CMON_BUSY_BIT == `CMON_DRDY_BIT) begin : g_bad_stat
			$error("status bits overlap");
		end
		if (`CMON_AUX_SRC_BIT == `CMON_AUX_REF_BIT) begin : g_bad_fcfg
			$error("auxiliary select bits overlap");
		end
	endgenerate

	localparam logic [`CMON_CNT_W-1:0] CH_LAST = `CMON_CNT_W'(CH_CYCLES - 1);
	localparam logic [`CMON_CNT_W-1:0] OVH_LAST = `CMON_CNT_W'(OVH_CYCLES - 1);

	cmon_st_t st_r;
	cmon_st_t st_nxt;
	logic [`CMON_RES_W-1:0] clamped;
	logic pin_rise;
	logic start;
	logic [`CMON_CHAN_W-1:0] nx;

	// ****************************************
	// saturation of the converter value
	// ****************************************
	cmon_clamp #(
		.RAW_W(`CMON_RAW_W),
		.RES_W(`CMON_RES_W)
	) u_clamp (
		.raw(adc_raw),
		.res(clamped)
	);

	// ****************************************
	// decoding helpers
	// ****************************************
	function automatic logic chan_on(input logic [`CMON_CHAN_W-1:0] c, input cmon_st_t s);
		logic [2:0] n;
		logic on;
		n = (s.cell_count_field > `CMON_CELLS_MAX) ? `CMON_CELLS_MAX : s.cell_count_field;
		on = 1'b0;
		if (c < `CMON_CH_TS1) begin
			on = (c[2:0] <= n);
		end else if (c == `CMON_CH_TS1) begin
			on = s.ts1_en;
		end else if (c == `CMON_CH_TS2) begin
			on = s.ts2_en;
		end else if (c == `CMON_CH_AUX) begin
			on = s.aux_en;
		end
		return on;
	endfunction

	// first enabled channel at or above a given code
	function automatic logic [`CMON_CHAN_W-1:0] next_chan(input logic [`CMON_CHAN_W-1:0] from,
		input cmon_st_t s);
		logic [`CMON_CHAN_W-1:0] r;
		logic [`CMON_CHAN_W-1:0] c;
		r = `CMON_CH_NONE;
		for (int i = `CMON_NUM_CH - 1; i >= 0; i--) begin
			c = `CMON_CHAN_W'(i);
			if (c >= from && chan_on(c, s)) begin
				r = c;
			end
		end
		return r;
	endfunction

	// front-end selection for one channel
	function automatic cmon_fe_t fe_for(input logic [`CMON_CHAN_W-1:0] c, input cmon_st_t s);
		cmon_fe_t f;
		f.chan = c;
		f.sample = 1'b1;
		f.aux_brick = 1'b0;
		f.ref_regulator = 1'b0;
		if (c == `CMON_CH_TS1 || c == `CMON_CH_TS2) begin
			f.ref_regulator = 1'b1;
		end else if (c == `CMON_CH_AUX) begin
			f.aux_brick = s.aux_source_select;
			if (s.aux_source_select) begin
				f.ref_regulator = 1'b0;
			end else begin
				f.ref_regulator = ~s.aux_reference_select;
			end
		end
		return f;
	endfunction

	// result register pair index; 0 aux, 1..6 cells, 7..8 temperatures
	function automatic logic [7:0] read_byte(input logic [`CMON_ADDR_W-1:0] a,
		input cmon_st_t s);
		logic [`CMON_ADDR_W-1:0] pair;
		logic [`CMON_CHAN_W-1:0] idx;
		logic [15:0] word;
		logic [7:0] b;
		pair = (a - `CMON_AUX_RESULT_HIGH) >> 1;
		idx = `CMON_CH_AUX;
		word = '0;
		b = '0;
		if (a >= `CMON_AUX_RESULT_HIGH && a <= `CMON_LAST_RESULT_LOW) begin
			if (pair != '0) begin
				idx = `CMON_CHAN_W'(pair - 8'h01);
			end
			word = {2'h0, s.res[idx]};
			b = (a[0]) ? word[15:8] : word[7:0];
		end else if (a == `CMON_STATUS) begin
			b[`CMON_BUSY_BIT] = s.busy;
			b[`CMON_DRDY_BIT] = s.drdy;
		end else if (a == `CMON_ADC_CONTROL) begin
			b[`CMON_CELLS_MSB:0] = s.cell_count_field;
			b[`CMON_TS1_BIT] = s.ts1_en;
			b[`CMON_TS2_BIT] = s.ts2_en;
			b[`CMON_AUX_EN_BIT] = s.aux_en;
		end else if (a == `CMON_CONVERT_CONTROL) begin
			b[`CMON_CONV_BIT] = s.conv_bit;
		end else if (a == `CMON_FUNCTION_CONFIG) begin
			b[`CMON_AUX_SRC_BIT] = s.aux_source_select;
			b[`CMON_AUX_REF_BIT] = s.aux_reference_select;
		end
		return b;
	endfunction

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.fe.sample = 1'b0;
		st_nxt.pin_s1 = conv_pin;
		st_nxt.pin_s2 = st_r.pin_s1;
		st_nxt.pin_prev = st_r.pin_s2;
		pin_rise = st_r.pin_s2 & ~st_r.pin_prev;
		start = pin_rise | (st_r.conv_bit & ~st_r.pin_s2);
		nx = next_chan(st_r.chan + `CMON_CHAN_W'(1), st_r);

		// register writes
		if (reg_req.wr) begin
			unique case (reg_req.addr)
				`CMON_ADC_CONTROL: begin
					st_nxt.cell_count_field = reg_req.wdata[`CMON_CELLS_MSB:0];
					st_nxt.ts1_en = reg_req.wdata[`CMON_TS1_BIT];
					st_nxt.ts2_en = reg_req.wdata[`CMON_TS2_BIT];
					st_nxt.aux_en = reg_req.wdata[`CMON_AUX_EN_BIT];
				end
				`CMON_CONVERT_CONTROL: begin
					if (reg_req.wdata[`CMON_CONV_BIT]) begin
						st_nxt.conv_bit = 1'b1;
					end
				end
				`CMON_FUNCTION_CONFIG: begin
					st_nxt.aux_source_select = reg_req.wdata[`CMON_AUX_SRC_BIT];
					st_nxt.aux_reference_select = reg_req.wdata[`CMON_AUX_REF_BIT];
				end
				default: begin
				end
			endcase
		end

		// register reads
		if (reg_req.rd) begin
			st_nxt.rdata = read_byte(reg_req.addr, st_r);
		end

		// conversion sequencer
		unique case (st_r.state)
			CMON_S_IDLE: begin
				if (start) begin
					st_nxt.state = CMON_S_OVH;
					st_nxt.cnt = '0;
					st_nxt.busy = 1'b1;
					st_nxt.drdy = 1'b0;
					st_nxt.chan = next_chan('0, st_r);
				end
			end
			CMON_S_OVH: begin
				st_nxt.cnt = st_r.cnt + `CMON_CNT_W'(1);
				if (st_r.cnt == OVH_LAST) begin
					st_nxt.cnt = '0;
					st_nxt.state = CMON_S_CONV;
					st_nxt.fe = fe_for(st_r.chan, st_r);
				end
			end
			CMON_S_CONV: begin
				st_nxt.cnt = st_r.cnt + `CMON_CNT_W'(1);
				if (st_r.cnt == CH_LAST) begin
					st_nxt.res[st_r.chan] = clamped;
					st_nxt.cnt = '0;
					if (nx == `CMON_CH_NONE) begin
						st_nxt.state = CMON_S_IDLE;
						st_nxt.busy = 1'b0;
						st_nxt.drdy = 1'b1;
						st_nxt.conv_bit = 1'b0;
					end else begin
						st_nxt.chan = nx;
						st_nxt.fe = fe_for(nx, st_r);
					end
				end
			end
		endcase
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_r <= '0;
			st_r.state <= CMON_S_IDLE;
			st_r.cell_count_field <= `CMON_CELLS_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign reg_rdata_r = st_r.rdata;
	assign fe_sel_r = st_r.fe;
	assign busy_r = st_r.busy;
	assign data_ready_r = st_r.drdy;
endmodule

// ### rtl/cmon_clamp.sv
// saturates a trimmed signed converter value into the unsigned result range
`timescale 1ns/10ps
module cmon_clamp #(
	parameter int RAW_W = 16,
	parameter int RES_W = 14
) (
	input wire logic signed [RAW_W-1:0] raw,
	output logic [RES_W-1:0] res
);
	localparam logic signed [RAW_W-1:0] TOP = RAW_W'((1 << RES_W) - 1);

	generate
		if (RAW_W <= RES_W) begin : g_bad
			$error("raw width must exceed result width");
		end
	endgenerate

	always_comb begin
		if (raw < 0) begin
			res = '0;
		end else if (raw > TOP) begin
			res = '1;
		end else begin
			res = raw[RES_W-1:0];
		end
	end
endmodule

// ### rtl/cmon_map.svh
// register offsets, field positions, reset values and timing counts of the result path
`ifndef CMON_MAP_SVH
`define CMON_MAP_SVH

// ****************************************
// widths
// ****************************************
`define CMON_RES_W 14
`define CMON_RAW_W 16
`define CMON_ADDR_W 8
`define CMON_CHAN_W 4
`define CMON_CNT_W 12
`define CMON_NUM_CH 9

// ****************************************
// result register pairs, status and control registers
// ****************************************
`define CMON_AUX_RESULT_HIGH 8'h01
`define CMON_CELL1_RESULT_HIGH 8'h03
`define CMON_CELL1_RESULT_LOW 8'h04
`define CMON_LAST_RESULT_LOW 8'h12
`define CMON_STATUS 8'h00
`define CMON_ADC_CONTROL 8'h30
`define CMON_CONVERT_CONTROL 8'h31
`define CMON_FUNCTION_CONFIG 8'h40

// ****************************************
// fields
// ****************************************
`define CMON_CELLS_MSB 2
`define CMON_TS1_BIT 4
`define CMON_TS2_BIT 5
`define CMON_AUX_EN_BIT 6
`define CMON_CONV_BIT 0
`define CMON_AUX_SRC_BIT 4
`define CMON_AUX_REF_BIT 6
`define CMON_BUSY_BIT 0
`define CMON_DRDY_BIT 1
`define CMON_CELLS_MAX 3'h5
`define CMON_CELLS_RST 3'h0

// ****************************************
// channel codes of the front-end selector
// ****************************************
`define CMON_CH_TS1 4'h6
`define CMON_CH_TS2 4'h7
`define CMON_CH_AUX 4'h8
`define CMON_CH_NONE 4'hf

// ****************************************
// timing
// ****************************************
`define CMON_CLK_PERIOD_NS 5
`define CMON_CH_TIME_NS 6000
`define CMON_OVH_TIME_NS 6000
`define CMON_CH_CYCLES (`CMON_CH_TIME_NS / `CMON_CLK_PERIOD_NS)
`define CMON_OVH_CYCLES (`CMON_OVH_TIME_NS / `CMON_CLK_PERIOD_NS)

`endif

// ### rtl/cmon_pkg.sv
// types of the cell monitor converter result path
package cmon_pkg;
`include "cmon_map.svh"

	typedef enum logic [2:0] {
		CMON_S_IDLE = 3'b001,
		CMON_S_OVH = 3'b010,
		CMON_S_CONV = 3'b100
	} cmon_state_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [`CMON_ADDR_W-1:0] addr;
		logic [7:0] wdata;
	} cmon_req_t;

	typedef struct packed {
		logic [`CMON_CHAN_W-1:0] chan;
		logic aux_brick;
		logic ref_regulator;
		logic sample;
	} cmon_fe_t;

	typedef struct packed {
		cmon_state_t state;
		logic [`CMON_CNT_W-1:0] cnt;
		logic [`CMON_CHAN_W-1:0] chan;
		logic pin_s1;
		logic pin_s2;
		logic pin_prev;
		logic conv_bit;
		logic busy;
		logic drdy;
		logic [2:0] cell_count_field;
		logic ts1_en;
		logic ts2_en;
		logic aux_en;
		logic aux_source_select;
		logic aux_reference_select;
		logic [`CMON_NUM_CH-1:0][`CMON_RES_W-1:0] res;
		logic [7:0] rdata;
		cmon_fe_t fe;
	} cmon_st_t;
endpackage

// ### verif/cell_monitor_adc_result_path_tb.sv
// self-checking bench of the result path
`timescale 1ns/10ps
module cell_monitor_adc_result_path_tb;
	import cmon_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic conv_pin = 1'b0;
	logic signed [15:0] adc_raw = '0;
	cmon_req_t reg_req;
	logic [7:0] reg_rdata_r, hi, lo;
	cmon_fe_t fe_sel_r;
	logic busy_r, data_ready_r;
	int fails = 0;
	int num_checks = 0;
	int nbusy;
	logic [3:0] seq[$];
	logic [1:0] fe_of[16];
	always #2.5 clk_sys = ~clk_sys;
	cmon_adc_path #(.CH_CYCLES(4), .OVH_CYCLES(2)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.reg_req(reg_req), .reg_rdata_r(reg_rdata_r), .conv_pin(conv_pin), .adc_raw(adc_raw),
		.fe_sel_r(fe_sel_r), .busy_r(busy_r), .data_ready_r(data_ready_r));
	cmon_host host (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata_r(reg_rdata_r));
	// ****
	// monitor and helpers
	// ****
	always @(posedge clk_sys) begin
		if (busy_r === 1'b1) begin
			nbusy++;
		end
		if (fe_sel_r.sample === 1'b1) begin
			seq.push_back(fe_sel_r.chan);
			fe_of[fe_sel_r.chan] = {fe_sel_r.aux_brick, fe_sel_r.ref_regulator};
		end
	end
	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic end_of_test();
		if (fails == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic convert(input logic [7:0] ctl, input logic [7:0] fc, input logic [15:0] raw,
		input bit hw);
		int i;
		host.wr(8'h30, ctl);
		host.wr(8'h40, fc);
		adc_raw <= raw;
		seq.delete();
		nbusy = 0;
		if (hw) begin
			conv_pin <= 1'b1;
		end else begin
			host.wr(8'h31, 8'h01);
		end
		for (i = 0; i < 300 && !(nbusy > 0 && busy_r === 1'b0); i++) begin
			@(posedge clk_sys);
			#1;
		end
		check("data ready", 1, data_ready_r);
		check("cycle length", 2 + 4 * seq.size(), nbusy);
		@(posedge clk_sys);
		conv_pin <= 1'b0;
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_clamp();
		logic [15:0] raws[5] = '{16'hfffb, 16'h7fff, 16'h4000, 16'h0000, 16'h224d};
		logic [15:0] exps[5] = '{16'h0000, 16'h3fff, 16'h3fff, 16'h0000, 16'h224d};
		for (int k = 0; k < 5; k++) begin
			convert(8'h00, 8'h00, raws[k], 0);
			host.rd(8'h03, hi);
			host.rd(8'h04, lo);
			check("cell one pair", exps[k], {hi, lo});
		end
		check("cell mv", 3349, host.cell_mv({hi, lo}));
		host.rd(8'h20, hi);
		check("unmapped", 8'h00, hi);
	endtask
	task automatic t_cells();
		for (int n = 0; n < 8; n++) begin
			convert(8'(n), 8'h00, 16'h0100, 0);
			check("cells done", (n > 5) ? 6 : n + 1, seq.size());
		end
	endtask
	task automatic t_aux();
		logic [7:0] fcs[4] = '{8'h00, 8'h10, 8'h40, 8'h50};
		for (int k = 0; k < 4; k++) begin
			convert(8'h75, fcs[k], 16'h2000, k == 3);
			check("aux fe", {fcs[k][4], ~fcs[k][4] & ~fcs[k][6]}, fe_of[8]);
			check("cell ref", 0, fe_of[0][0]);
		end
		for (int i = 0; i < 9; i++) begin
			check("order", i, seq[i]);
		end
		host.rd(8'h01, hi);
		host.rd(8'h02, lo);
		check("aux mv", 1250, host.aux_mv({hi, lo}));
		check("brick mv", 16666, host.brick_mv({hi, lo}));
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		end_of_test();
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_clamp();
		t_cells();
		t_aux();
		end_of_test();
	end
endmodule

// ### verif/cmon_adc_path_chk.sv
// assertions on the ports of the result path
`timescale 1ns/10ps
`include "cmon_map.svh"
module cmon_adc_path_chk #(
	parameter int CH_CYCLES = 4,
	parameter int OVH_CYCLES = 2
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire cmon_pkg::cmon_req_t reg_req,
	input wire logic [7:0] reg_rdata_r,
	input wire logic conv_pin,
	input wire logic signed [`CMON_RAW_W-1:0] adc_raw,
	input wire cmon_pkg::cmon_fe_t fe_sel_r,
	input wire logic busy_r,
	input wire logic data_ready_r
);
	import cmon_pkg::*;
	// ****
	// properties
	// ****
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	property p_done; $fell(busy_r) |-> data_ready_r; endproperty
	a_done: assert property (p_done) else $error("no data ready at end");
	property p_clr; $rose(busy_r) |-> !data_ready_r; endproperty
	a_clr: assert property (p_clr) else $error("data ready kept at start");
	property p_first; $rose(busy_r) |-> ##OVH_CYCLES (fe_sel_r.sample && fe_sel_r.chan == 4'h0);
	endproperty
	a_first: assert property (p_first) else $error("first slot not cell one");
	property p_gap; fe_sel_r.sample |=> !fe_sel_r.sample [*3]; endproperty
	a_gap: assert property (p_gap) else $error("slot too short");
	property p_end; $fell(busy_r) |-> $past(fe_sel_r.sample, CH_CYCLES); endproperty
	a_end: assert property (p_end) else $error("cycle end off slot");
	property p_rng; fe_sel_r.sample |-> fe_sel_r.chan <= `CMON_CH_AUX; endproperty
	a_rng: assert property (p_rng) else $error("bad channel");
	property p_brk; fe_sel_r.sample && fe_sel_r.chan == `CMON_CH_AUX && fe_sel_r.aux_brick
		|-> !fe_sel_r.ref_regulator; endproperty
	a_brk: assert property (p_brk) else $error("brick not on band-gap");
	property p_cref; fe_sel_r.sample && fe_sel_r.chan < 4'h6 |-> !fe_sel_r.ref_regulator;
	endproperty
	a_cref: assert property (p_cref) else $error("cell not on band-gap");
	property p_top; reg_req.rd && reg_req.addr[0] && reg_req.addr inside {[8'h01:8'h11]}
		|=> reg_rdata_r[7:6] == 2'b00; endproperty
	a_top: assert property (p_top) else $error("high byte top bits set");
	property p_unm; reg_req.rd && reg_req.addr == 8'h20 |=> reg_rdata_r == 8'h00; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	c_hw: cover property ($rose(busy_r) && conv_pin);
	c_brk: cover property (fe_sel_r.sample && fe_sel_r.aux_brick && fe_sel_r.chan == 4'h8);
	c_six: cover property (fe_sel_r.sample && fe_sel_r.chan == 4'h5);
endmodule
bind cmon_adc_path cmon_adc_path_chk #(.CH_CYCLES(CH_CYCLES), .OVH_CYCLES(OVH_CYCLES)) chk (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata_r(reg_rdata_r),
	.conv_pin(conv_pin), .adc_raw(adc_raw), .fe_sel_r(fe_sel_r), .busy_r(busy_r),
	.data_ready_r(data_ready_r));

// ### verif/cmon_host.sv
// host model: register access and result scaling
`timescale 1ns/10ps
module cmon_host (
	input wire logic clk_sys,
	output cmon_pkg::cmon_req_t reg_req,
	input wire logic [7:0] reg_rdata_r
);
	import cmon_pkg::*;
	initial reg_req = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_req <= '{1'b0, 1'b1, a, d};
		@(posedge clk_sys);
		reg_req <= '{1'b0, 1'b0, ~a, ~d};
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_req <= '{1'b1, 1'b0, a, 8'h00};
		@(posedge clk_sys);
		reg_req <= '{1'b0, 1'b0, ~a, 8'hff};
		#1;
		d = reg_rdata_r;
	endtask
	function automatic int cell_mv(input logic [15:0] v);
		return v * 6250 / 16383;
	endfunction
	function automatic int aux_mv(input logic [15:0] v);
		return v * 2500 / 16383;
	endfunction
	function automatic int brick_mv(input logic [15:0] v);
		return v * 33333 / 16384;
	endfunction
endmodule
